//--- logic/gpiop_defs.svh
// Constant definitions for the general-purpose port block.
`ifndef GPIOP_DEFS_SVH
`define GPIOP_DEFS_SVH

`define GPIOP_NUM_PORTS 3'd6
`define GPIOP_PORT_W    8
`define GPIOP_PIN_CNT   48
`define GPIOP_RST_VAL   8'hff
`define GPIOP_ZERO_BYTE 8'h00
`define GPIOP_ONE_BIT   8'h01
`define GPIOP_ADDR_W    8
`define GPIOP_DATA_BASE 8'h00
`define GPIOP_DIR_BASE  8'h08
`define GPIOP_DIR_BIT   3
`define GPIOP_HI_MASK   8'hf0
`define GPIOP_PFD_PIN   3
`define GPIOP_INT_PIN   5
`define GPIOP_PWM_BASE  24
`define GPIOP_PWM_CNT   4
`define GPIOP_ANA_BASE  8
`define GPIOP_ANA_CNT   8
`define GPIOP_WAKE_CNT  8

`endif

//--- logic/gpiop_pkg.sv
// Types shared by the general-purpose port block.
`include "gpiop_defs.svh"
package gpiop_pkg;

	typedef logic [`GPIOP_PORT_W-1:0] gpiop_byte_t;

	typedef enum logic [2:0] {
		OP_IDLE,
		OP_READ,
		OP_WRITE,
		OP_SET,
		OP_CLR
	} gpiop_op_e;

	typedef struct packed {
		logic [`GPIOP_PIN_CNT-1:0]  pull_up;
		logic [`GPIOP_WAKE_CNT-1:0] wake;
		logic                       freq_divider_out;
		logic [`GPIOP_PWM_CNT-1:0]  pwm;
	} gpiop_opt_s;

	typedef struct packed {
		logic                       ext_int_en;
		logic                       pfd_val;
		logic [`GPIOP_PWM_CNT-1:0]  pwm_val;
		logic [`GPIOP_ANA_CNT-1:0]  analog_sel;
	} gpiop_alt_s;

endpackage : gpiop_pkg

//--- logic/gpiop_pin_cell.sv
// One port pin: drive, pull-up and read-back selection.
`timescale 1ns/1ps
module gpiop_pin_cell (
	input  wire logic dir_in,
	input  wire logic latch,
	input  wire logic pin_in,
	input  wire logic alt_en,
	input  wire logic alt_val,
	input  wire logic analog,
	input  wire logic pu_opt,
	output logic      pin_out,
	output logic      pin_oe,
	output logic      pull_en,
	output logic      rd_bit
);

	always_comb begin
		pin_oe  = !dir_in && !analog;
		pin_out = (alt_en && !dir_in) ? alt_val : latch;
		pull_en = dir_in && pu_opt && !analog;
		rd_bit  = dir_in ? pin_in : latch;
	end

endmodule : gpiop_pin_cell

//--- logic/gpiop_top.sv
// General-purpose port block: six 8-bit ports behind data-memory locations.
`timescale 1ns/1ps
module gpiop_top
	import gpiop_pkg::*;
(
	input  wire logic                      ref_clk,
	input  wire logic                      rst,
	input  wire logic                      ce,
	input  wire logic                      mem_req,
	input  wire gpiop_op_e                 mem_op,
	input  wire logic [`GPIOP_ADDR_W-1:0]  mem_addr,
	input  wire logic [2:0]                bit_sel,
	input  wire gpiop_byte_t               mem_wdata,
	output gpiop_byte_t                    mem_rdata,
	input  wire logic [`GPIOP_PIN_CNT-1:0] pin_in,
	output logic [`GPIOP_PIN_CNT-1:0]      pin_out,
	output logic [`GPIOP_PIN_CNT-1:0]      pin_oe,
	output logic [`GPIOP_PIN_CNT-1:0]      pin_pull_en,
	input  wire gpiop_opt_s                opt,
	input  wire gpiop_alt_s                alt,
	input  wire logic                      power_down,
	output logic                           wake_req,
	output logic                           ext_int_n
);

	localparam int NP = `GPIOP_NUM_PORTS;
	localparam int PW = `GPIOP_PORT_W;

	gpiop_byte_t               data_reg [NP];
	gpiop_byte_t               data_next[NP];
	gpiop_byte_t               dir_reg  [NP];
	gpiop_byte_t               dir_next [NP];
	gpiop_byte_t               view_port[NP];
	gpiop_byte_t               rdata_reg;
	gpiop_byte_t               rdata_next;
	logic [`GPIOP_WAKE_CNT-1:0] prev_a_reg;
	logic [`GPIOP_WAKE_CNT-1:0] prev_a_next;
	logic                      wake_reg;
	logic                      wake_next;
	logic                      ext_int_reg;
	logic                      ext_int_next;
	logic [`GPIOP_PIN_CNT-1:0] rd_view;
	logic [`GPIOP_PIN_CNT-1:0] dir_flat;
	logic [`GPIOP_PIN_CNT-1:0] data_flat;
	logic [`GPIOP_PIN_CNT-1:0] alt_en_vec;
	logic [`GPIOP_PIN_CNT-1:0] alt_val_vec;
	logic [`GPIOP_PIN_CNT-1:0] ana_vec;
	logic [2:0]                idx;
	logic                      is_dir;
	logic                      hit;
	gpiop_byte_t               cur;
	gpiop_byte_t               mod;
	gpiop_byte_t               bit_mask;

	// Every pin gets an identical cell; registers are flattened for them.
	for (genvar p = 0; p < NP; p++) begin : g_port
		for (genvar b = 0; b < PW; b++) begin : g_bit
			assign dir_flat[p*PW+b]  = dir_reg[p][b];
			assign data_flat[p*PW+b] = data_reg[p][b];
			gpiop_pin_cell u_cell (
				.dir_in  (dir_flat[p*PW+b]),
				.latch   (data_flat[p*PW+b]),
				.pin_in  (pin_in[p*PW+b]),
				.alt_en  (alt_en_vec[p*PW+b]),
				.alt_val (alt_val_vec[p*PW+b]),
				.analog  (ana_vec[p*PW+b]),
				.pu_opt  (opt.pull_up[p*PW+b]),
				.pin_out (pin_out[p*PW+b]),
				.pin_oe  (pin_oe[p*PW+b]),
				.pull_en (pin_pull_en[p*PW+b]),
				.rd_bit  (rd_view[p*PW+b])
			);
		end
		assign view_port[p] = rd_view[p*PW +: PW];
	end

	// Shared-pin routing; options gate the divider and PWM sources, analog_sel alone claims the analog pins.
	always_comb begin
		alt_en_vec  = '0;
		alt_val_vec = '0;
		ana_vec     = '0;
		alt_en_vec[`GPIOP_PFD_PIN]  = opt.freq_divider_out;
		alt_val_vec[`GPIOP_PFD_PIN] = alt.pfd_val;
		alt_en_vec[`GPIOP_PWM_BASE +: `GPIOP_PWM_CNT]  = opt.pwm;
		alt_val_vec[`GPIOP_PWM_BASE +: `GPIOP_PWM_CNT] = alt.pwm_val;
		ana_vec[`GPIOP_ANA_BASE +: `GPIOP_ANA_CNT] = alt.analog_sel;
	end

	// Address decode: data ports at the low bank, directions above them.
	always_comb begin
		idx    = mem_addr[2:0];
		is_dir = mem_addr[`GPIOP_DIR_BIT];
		hit    = ((mem_addr & `GPIOP_HI_MASK) == `GPIOP_ZERO_BYTE) &&
		         (idx < `GPIOP_NUM_PORTS);
	end

	// Register file next values, including bit set and clear.
	always_comb begin
		for (int p = 0; p < NP; p++) begin
			data_next[p] = data_reg[p];
			dir_next[p]  = dir_reg[p];
		end
		rdata_next = rdata_reg;
		bit_mask   = `GPIOP_ONE_BIT << bit_sel;
		cur        = `GPIOP_ZERO_BYTE;
		mod        = `GPIOP_ZERO_BYTE;
		if (hit) begin
			// A data read shows live pins on inputs, the latch on outputs.
			cur = is_dir ? dir_reg[idx] : view_port[idx];
		end
		unique case (mem_op)
			OP_WRITE: mod = mem_wdata;
			OP_SET:   mod = cur | bit_mask;
			OP_CLR:   mod = cur & ~bit_mask;
			default:  mod = cur;
		endcase
		if (mem_req && hit) begin
			unique case (mem_op)
				OP_READ: begin
					rdata_next = cur;
				end
				OP_WRITE, OP_SET, OP_CLR: begin
					if (is_dir) begin
						dir_next[idx] = mod;
					end else begin
						data_next[idx] = mod;
					end
				end
				OP_IDLE: begin
				end
			endcase
		end else if (mem_req && (mem_op == OP_READ)) begin
			rdata_next = `GPIOP_ZERO_BYTE;
		end
	end

	// Wake-up edge detector and external interrupt level.
	always_comb begin
		prev_a_next  = pin_in[`GPIOP_WAKE_CNT-1:0];
		wake_next    = power_down &&
		               (|(opt.wake & prev_a_reg &
		                  ~pin_in[`GPIOP_WAKE_CNT-1:0]));
		ext_int_next = 1'b1;
		if (alt.ext_int_en && dir_reg[0][`GPIOP_INT_PIN]) begin
			ext_int_next = pin_in[`GPIOP_INT_PIN];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			for (int p = 0; p < NP; p++) begin
				data_reg[p] <= `GPIOP_RST_VAL;
				dir_reg[p]  <= `GPIOP_RST_VAL;
			end
			rdata_reg   <= `GPIOP_ZERO_BYTE;
			prev_a_reg  <= '0;
			wake_reg    <= 1'b0;
			ext_int_reg <= 1'b1;
		end else if (ce) begin
			for (int p = 0; p < NP; p++) begin
				data_reg[p] <= data_next[p];
				dir_reg[p]  <= dir_next[p];
			end
			rdata_reg   <= rdata_next;
			prev_a_reg  <= prev_a_next;
			wake_reg    <= wake_next;
			ext_int_reg <= ext_int_next;
		end
	end

	assign mem_rdata = rdata_reg;
	assign wake_req  = wake_reg;
	assign ext_int_n = ext_int_reg;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	logic rst_d_reg;
	always_ff @(posedge ref_clk) begin
		rst_d_reg <= rst;
	end

	sequence s_read_a;
		ce && mem_req && mem_op == OP_READ && mem_addr == `GPIOP_DATA_BASE;
	endsequence

	sequence s_fall_a;
		ce && power_down && |(opt.wake & pin_in[`GPIOP_WAKE_CNT-1:0])
		##1 ce && power_down &&
		|(opt.wake & $past(pin_in[`GPIOP_WAKE_CNT-1:0]) &
		  ~pin_in[`GPIOP_WAKE_CNT-1:0]);
	endsequence

	AST_RESET_ONES: assert property (
		@(posedge ref_clk) disable iff (1'b0)
		rst |=> data_reg[0] == `GPIOP_RST_VAL &&
		        dir_reg[5] == `GPIOP_RST_VAL && pin_oe == '0)
		else $error("reset did not leave ports as inputs at all ones");

	AST_INPUT_NO_DRIVE: assert property (
		(pin_oe & dir_flat) == '0)
		else $error("pin driven while its direction bit selects input");

	AST_OUT_DRIVES_LATCH: assert property (
		!dir_reg[2][0] |-> pin_oe[16] && pin_out[16] == data_reg[2][0])
		else $error("output pin does not follow its latch");

	AST_WRITE_STORES: assert property (
		ce && mem_req && mem_op == OP_WRITE &&
		mem_addr == `GPIOP_DATA_BASE + 8'h02
		|=> data_reg[2] == $past(mem_wdata) ##1 data_reg[2] == $past(mem_wdata, 2)
		    || $past(ce && mem_req))
		else $error("written latch value not stored or not held");

	AST_LATCH_HOLDS: assert property (
		!(ce && mem_req && mem_addr == `GPIOP_DATA_BASE) && !rst_d_reg
		|=> $stable(data_reg[0]))
		else $error("port A latch changed without a write");

	AST_READ_INPUTS: assert property (
		s_read_a |=> (mem_rdata & $past(dir_reg[0])) ==
		             ($past(pin_in[7:0]) & $past(dir_reg[0])))
		else $error("input bits did not read the sampled pin level");

	AST_READ_OUTPUTS: assert property (
		s_read_a |=> (mem_rdata & ~$past(dir_reg[0])) ==
		             ($past(data_reg[0]) & ~$past(dir_reg[0])))
		else $error("output bits did not read the latch");

	AST_SET_BIT_RMW: assert property (
		ce && mem_req && mem_op == OP_SET &&
		mem_addr == `GPIOP_DATA_BASE + 8'h01
		|=> data_reg[1] == ($past(view_port[1]) |
		                    ($past(bit_mask))))
		else $error("bit set did not write back the modified port byte");

	AST_DIR_CLEAR: assert property (
		ce && mem_req && mem_op == OP_CLR &&
		mem_addr == `GPIOP_DIR_BASE + 8'h03
		|=> dir_reg[3] == ($past(dir_reg[3]) & ~$past(bit_mask)))
		else $error("direction bit clear wrong");

	AST_PULL_ONLY_INPUT: assert property (
		(pin_pull_en & ~(dir_flat & opt.pull_up)) == '0)
		else $error("pull-up active on an output or unselected pin");

	AST_ANALOG_NO_PULL: assert property (
		(pin_pull_en[`GPIOP_ANA_BASE +: `GPIOP_ANA_CNT] & alt.analog_sel) == '0)
		else $error("pull-up left on an analog input");

	AST_WAKE_EDGE: assert property (
		s_fall_a |=> wake_req)
		else $error("wake-up pin fell during power-down without a wake");

	AST_INT_OUTPUT: assert property (
		ce && !dir_reg[0][`GPIOP_INT_PIN] |=> ext_int_n)
		else $error("interrupt seen from a pin set as output");

	AST_PFD_ROUTE: assert property (
		opt.freq_divider_out && !dir_reg[0][`GPIOP_PFD_PIN]
		|-> pin_oe[`GPIOP_PFD_PIN] && pin_out[`GPIOP_PFD_PIN] == alt.pfd_val)
		else $error("divider output not on its pin");

	AST_PWM_ROUTE: assert property (
		opt.pwm[0] && !dir_reg[3][0]
		|-> pin_out[`GPIOP_PWM_BASE] == alt.pwm_val[0])
		else $error("duty output not on its pin");

	AST_INT_FOLLOWS_PIN: assert property (
		ce && alt.ext_int_en && dir_reg[0][`GPIOP_INT_PIN]
		|=> ext_int_n == $past(pin_in[`GPIOP_INT_PIN]))
		else $error("interrupt level does not follow its input pin");

	AST_UNMAPPED_READ: assert property (
		ce && mem_req && mem_op == OP_READ &&
		mem_addr[2:0] >= `GPIOP_NUM_PORTS
		|=> mem_rdata == `GPIOP_ZERO_BYTE)
		else $error("read outside the six ports returned nonzero data");

	AST_PFD_AS_INPUT: assert property (
		opt.freq_divider_out && dir_reg[0][`GPIOP_PFD_PIN]
		|-> !pin_oe[`GPIOP_PFD_PIN] &&
		    pin_pull_en[`GPIOP_PFD_PIN] == opt.pull_up[`GPIOP_PFD_PIN])
		else $error("divider pin set as input is not a plain input");

endmodule : gpiop_top

//--- bench/gpiop_board.sv
// Board model: external drivers, pull-ups and floating pins seen by the ports.
`timescale 1ns/1ps
module gpiop_board (
	input  wire logic [47:0] pin_out,
	input  wire logic [47:0] pin_oe,
	input  wire logic [47:0] pin_pull_en,
	input  wire logic [47:0] ext_drv,
	input  wire logic [47:0] ext_val,
	output logic [47:0]      pin_in
);
	// An undriven pin without pull-up shows the inverse of its ext_val bit.
	assign pin_in = (pin_oe & pin_out)
		| (~pin_oe & ext_drv & ext_val)
		| (~pin_oe & ~ext_drv & pin_pull_en)
		| (~pin_oe & ~ext_drv & ~pin_pull_en & ~ext_val);
endmodule : gpiop_board

//--- bench/tb_gpiop_top.sv
// Self-checking bench for the general-purpose port block.
`timescale 1ns/1ps
`include "gpiop_defs.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
	$display("FAIL %s exp %h got %h", nm, e, g); end end
module tb_gpiop_top import gpiop_pkg::*;;
	logic        ref_clk, rst, ce, mem_req, power_down, wake_req, ext_int_n;
	gpiop_op_e   mem_op;
	logic [7:0]  mem_addr;
	logic [2:0]  bit_sel;
	gpiop_byte_t mem_wdata, mem_rdata, e;
	logic [47:0] pin_in, pin_out, pin_oe, pin_pull_en, ext_drv, ext_val;
	gpiop_opt_s  opt;
	gpiop_alt_s  alt;
	gpiop_byte_t lat [6];
	gpiop_byte_t dr [6];
	gpiop_byte_t exp_q [$];
	int          n_fail, cmp_count;
	logic        pend;
	logic [15:0] rnd;

	gpiop_top gpiop_top_i (.ref_clk(ref_clk), .rst(rst), .ce(ce),
		.mem_req(mem_req), .mem_op(mem_op), .mem_addr(mem_addr),
		.bit_sel(bit_sel), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pull_en(pin_pull_en), .opt(opt), .alt(alt),
		.power_down(power_down), .wake_req(wake_req), .ext_int_n(ext_int_n));
	gpiop_board gpiop_board_i (.pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pull_en(pin_pull_en), .ext_drv(ext_drv), .ext_val(ext_val),
		.pin_in(pin_in));

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	// Read view: live level for input bits, latch for output bits.
	function automatic gpiop_byte_t view(input int p);
		gpiop_byte_t v;
		for (int b = 0; b < 8; b++) begin
			v[b] = dr[p][b] ? (ext_drv[p*8+b] ? ext_val[p*8+b] : 1'b1)
				: lat[p][b];
		end
		return v;
	endfunction : view

	task automatic acc(input gpiop_op_e op, input logic [7:0] a,
		input logic [2:0] b, input gpiop_byte_t d);
		gpiop_byte_t v;
		int p;
		@(posedge ref_clk);
		#1;
		mem_req = 1'b1;
		mem_op = op;
		mem_addr = a;
		bit_sel = b;
		mem_wdata = d;
		p = a[2:0];
		v = (a < 8'h06) ? view(p) : (a >= 8'h08 && a < 8'h0e) ? dr[p] : 8'h00;
		if (op == OP_READ && ce) exp_q.push_back(v);
		if (op == OP_SET) v[b] = 1'b1;
		if (op == OP_CLR) v[b] = 1'b0;
		if (op == OP_WRITE) v = d;
		if (op != OP_READ && ce && a < 8'h06) lat[p] = v;
		if (op != OP_READ && ce && a >= 8'h08 && a < 8'h0e) dr[p] = v;
	endtask : acc

	task automatic idle();
		@(posedge ref_clk);
		#1;
		mem_req = 1'b0;
	endtask : idle

	task automatic settle();
		logic [47:0] oe_e, out_e, pu_e;
		logic ie;
		idle();
		idle();
		for (int i = 0; i < 48; i++) begin
			oe_e[i] = !dr[i/8][i%8] && !(i/8 == 1 && alt.analog_sel[i%8]);
			pu_e[i] = dr[i/8][i%8] && opt.pull_up[i]
				&& !(i/8 == 1 && alt.analog_sel[i%8]);
			out_e[i] = lat[i/8][i%8];
			if (i == 3 && opt.freq_divider_out) out_e[i] = alt.pfd_val;
			if (i >= 24 && i < 28 && opt.pwm[i-24]) out_e[i] = alt.pwm_val[i-24];
		end
		ie = (alt.ext_int_en && dr[0][5]) ? ext_val[5] : 1'b1;
		`CHK("pin_oe", oe_e, pin_oe)
		`CHK("pin_out", out_e & oe_e, pin_out & oe_e)
		`CHK("pin_pull_en", pu_e, pin_pull_en)
		`CHK("ext_int_n", ie, ext_int_n)
	endtask : settle

	task automatic read_all();
		for (int p = 0; p < 6; p++) begin
			acc(OP_READ, p[7:0], 3'h0, 8'h00);
			acc(OP_READ, 8'h08 + p[7:0], 3'h0, 8'h00);
		end
	endtask : read_all

	task automatic conclude();
		$display("counts: %0d compared, %0d failed", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : conclude

	always @(negedge ref_clk) begin
		if (pend) begin
			e = exp_q.pop_front();
			`CHK("mem_rdata", e, mem_rdata)
		end
		pend = mem_req && mem_op == OP_READ && ce && !rst;
	end

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	initial begin
		repeat (5000) @(posedge ref_clk);
		n_fail++;
		conclude();
	end

	initial begin
		{ce, rst, mem_req, power_down, pend} = 5'b11000;
		mem_op = OP_IDLE;
		{mem_addr, bit_sel, mem_wdata} = '0;
		{ext_drv, ext_val, alt} = {96'hffffffffffffffffffffffff, 14'h0000};
		opt = {48'hffffffffffff, 8'hfe, 1'b1, 4'hf};
		{rnd, n_fail, cmp_count} = {16'd51888, 64'h0};
		for (int p = 0; p < 6; p++) begin
			lat[p] = 8'hff;
			dr[p] = 8'hff;
		end
		repeat (4) @(posedge ref_clk);
		#1 rst = 1'b0;
		for (int a = 0; a < 16; a++) acc(OP_READ, a[7:0], 3'h0, 8'h00);
		settle();
		$display("test reset done");
		repeat (8) begin
			for (int p = 0; p < 6; p++) begin
				rnd = lfsr(rnd);
				acc(OP_WRITE, 8'h08 + p[7:0], 3'h0, rnd[7:0]);
				acc(OP_WRITE, p[7:0], 3'h0, rnd[15:8]);
			end
			rnd = lfsr(rnd);
			ext_val = {3{rnd}};
			alt = gpiop_alt_s'(rnd[13:0]);
			read_all();
			settle();
		end
		$display("test random done");
		for (int p = 0; p < 6; p++) begin
			rnd = lfsr(rnd);
			acc(OP_SET, p[7:0], rnd[2:0], 8'h00);
			acc(OP_CLR, 8'h08 + p[7:0], rnd[5:3], 8'h00);
			acc(OP_CLR, p[7:0], rnd[8:6], 8'h00);
			acc(OP_SET, 8'h08 + p[7:0], rnd[11:9], 8'h00);
		end
		read_all();
		settle();
		$display("test bit ops done");
		acc(OP_WRITE, 8'h06, 3'h0, 8'h5a);
		acc(OP_WRITE, 8'h0e, 3'h0, 8'ha5);
		idle();
		ce = 1'b0;
		acc(OP_WRITE, 8'h0a, 3'h0, 8'h00);
		idle();
		ce = 1'b1;
		acc(OP_READ, 8'h06, 3'h0, 8'h00);
		acc(OP_READ, 8'hff, 3'h0, 8'h00);
		read_all();
		$display("test unmapped done");
		ext_drv[16] = 1'b0;
		acc(OP_WRITE, 8'h0a, 3'h0, 8'hff);
		acc(OP_READ, 8'h02, 3'h0, 8'h00);
		settle();
		$display("test pull-up done");
		acc(OP_WRITE, 8'h08, 3'h0, 8'hff);
		power_down = 1'b1;
		ext_val[2:0] = 3'b111;
		idle();
		idle();
		ext_val[0] = 1'b0;
		idle();
		`CHK("wake_req", 1'b0, wake_req)
		ext_val[2] = 1'b0;
		idle();
		`CHK("wake_req", 1'b1, wake_req)
		$display("test wake done");
		rst = 1'b1;
		idle();
		rst = 1'b0;
		for (int p = 0; p < 6; p++) begin
			lat[p] = 8'hff;
			dr[p] = 8'hff;
		end
		read_all();
		settle();
		`CHK("wake_req", 1'b0, wake_req)
		$display("test mid reset done");
		conclude();
	end
endmodule : tb_gpiop_top
